// ===== core/crt_regs.svh
`ifndef CRT_REGS_SVH
`define CRT_REGS_SVH

// ----------------------------------------------------------------
// register byte addresses in the special-function space
// ----------------------------------------------------------------
`define CRT_ADDR_CTL 8'hc8
`define CRT_ADDR_MODE 8'hc9
`define CRT_ADDR_CAP_LO 8'hca
`define CRT_ADDR_CAP_HI 8'hcb
`define CRT_ADDR_CNT_LO 8'hcc
`define CRT_ADDR_CNT_HI 8'hcd

// ----------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------
`define CRT_RST_BYTE 8'h00
`define CRT_RST_WORD 16'h0000
`define CRT_CNT_MAX 16'hffff
`define CRT_MODE_DOWN_COUNT_ENABLE 0
`define CRT_MODE_OE 1
`define CRT_MODE_MASK 8'h03
`define CRT_UNMAPPED_READ 8'h00

// ----------------------------------------------------------------
// machine-cycle timing, in oscillator periods
// ----------------------------------------------------------------
`define CRT_OSC_PER_MC 12
`define CRT_PH_LAST 4'hb
`define CRT_PH_FIRST 4'h0
`define CRT_PH_S3P1 4'h4
`define CRT_PH_S5P2 4'h9

`endif

// ===== core/crt_pkg.sv
package crt_pkg;

   // control register fields, bit 7 down to bit 0
   typedef struct packed {
      logic tf;
      logic exf;
      logic rclk;
      logic tx_baud_select;
      logic exen;
      logic run;
      logic ct;
      logic cprl;
   } crt_ctl_t;

   // operating mode decoded from the control fields
   typedef enum logic [1:0] {
      CRT_OFF = 2'b00,
      CRT_RELOAD = 2'b01,
      CRT_CAPTURE = 2'b10,
      CRT_BAUD = 2'b11
   } crt_mode_t;

endpackage

// ===== core/crt_timer.sv
`timescale 1ns/100ps
`include "crt_regs.svh"

// What this block does
// - overflow flag sticky, never set in baud
// - trigger capture/reload sets external event flag
// - event flag requests interrupt except up/down
// - receive clock from our or other overflows
// - transmit clock from our or other overflows
// - trigger edges act only with trigger enable
// - count only while run bit set
// - count machine cycles or count pin edges
// - capture or reload chosen by select bit
// - baud mode always reloads on overflow
// - timer advances once per twelve clocks outside baud mode
// - count pin sampled at S5P2, high-low counts
// - count edge visible at next S3P1
// - mode decoded from baud, select, run bits
// - capture without trigger is plain counter
// - trigger edge copies count into capture
// - up/down counting with direction from trigger
// - baud mode counts every state time
// - baud mode trigger only sets event flag
// - interrupt is OR of both flags, event flag masked by up/down enable
module crt_timer
   import crt_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic [7:0] i_sfr_addr,
   input wire logic i_sfr_wr,
   input wire logic [7:0] i_sfr_wdata,
   output logic [7:0] o_sfr_rdata,
   output logic o_sfr_hit,
   input wire logic i_count_pin,
   input wire logic i_trigger_pin,
   input wire logic i_other_ovf,
   input wire logic i_irq_enable,
   output logic o_timer_irq,
   output logic o_rx_baud_clk,
   output logic o_tx_baud_clk
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   crt_ctl_t ctl_q;
   crt_mode_t mode;
   logic [7:0] mode_reg_q;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [15:0] cap_q;
   logic [3:0] phase_q;
   logic cnt_s1_q, cnt_s2_q, trg_s1_q, trg_s2_q;
   logic cnt_samp_q, trg_samp_q;
   logic cnt_pend_q, trg_pend_q;
   logic mc_tick, st_tick, cnt_evt, trg_evt, inc;
   logic dmode, count_down, ovf, unf, tf_set, exf_set, exf_tog, cap_load;
   logic baud_pulse;
   logic wr_ctl, wr_mode, wr_cap_lo, wr_cap_hi, wr_cnt_lo, wr_cnt_hi;
   logic [7:0] rd_mux;

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   assign wr_ctl = i_sfr_wr && (i_sfr_addr == `CRT_ADDR_CTL);
   assign wr_mode = i_sfr_wr && (i_sfr_addr == `CRT_ADDR_MODE);
   assign wr_cap_lo = i_sfr_wr && (i_sfr_addr == `CRT_ADDR_CAP_LO);
   assign wr_cap_hi = i_sfr_wr && (i_sfr_addr == `CRT_ADDR_CAP_HI);
   assign wr_cnt_lo = i_sfr_wr && (i_sfr_addr == `CRT_ADDR_CNT_LO);
   assign wr_cnt_hi = i_sfr_wr && (i_sfr_addr == `CRT_ADDR_CNT_HI);

   // read mux, unmapped addresses read as zero
   always_comb
   begin
      o_sfr_hit = 1'b1;
      case (i_sfr_addr)
         `CRT_ADDR_CTL: rd_mux = ctl_q;
         `CRT_ADDR_MODE: rd_mux = mode_reg_q & `CRT_MODE_MASK;
         `CRT_ADDR_CAP_LO: rd_mux = cap_q[7:0];
         `CRT_ADDR_CAP_HI: rd_mux = cap_q[15:8];
         `CRT_ADDR_CNT_LO: rd_mux = cnt_q[7:0];
         `CRT_ADDR_CNT_HI: rd_mux = cnt_q[15:8];
         default:
         begin
            rd_mux = `CRT_UNMAPPED_READ;
            o_sfr_hit = 1'b0;
         end
      endcase
   end

   // registered read data, one cycle after the address
   always_ff @(posedge i_mclk)
   begin
      if (!i_resetn)
         o_sfr_rdata <= `CRT_RST_BYTE;
      else
         o_sfr_rdata <= rd_mux;
   end

   // ----------------------------------------------------------------
   // machine-cycle phase, twelve oscillator periods per cycle
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (!i_resetn || phase_q == `CRT_PH_LAST)
         phase_q <= `CRT_PH_FIRST;
      else
         phase_q <= phase_q + 4'h1;
   end

   assign mc_tick = (phase_q == `CRT_PH_S3P1);
   assign st_tick = phase_q[0];

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (!i_resetn)
      begin
         cnt_s1_q <= 1'b1;
         cnt_s2_q <= 1'b1;
         trg_s1_q <= 1'b1;
         trg_s2_q <= 1'b1;
      end
      else
      begin
         cnt_s1_q <= i_count_pin;
         cnt_s2_q <= cnt_s1_q;
         trg_s1_q <= i_trigger_pin;
         trg_s2_q <= trg_s1_q;
      end
   end

   // ----------------------------------------------------------------
   // falling-edge detection, sampled once per machine cycle
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (!i_resetn)
      begin
         cnt_samp_q <= 1'b1;
         trg_samp_q <= 1'b1;
         cnt_pend_q <= 1'b0;
         trg_pend_q <= 1'b0;
      end
      else
      begin
         if (phase_q == `CRT_PH_S5P2)
         begin
            cnt_samp_q <= cnt_s2_q;
            trg_samp_q <= trg_s2_q;
            cnt_pend_q <= cnt_samp_q && !cnt_s2_q;
            trg_pend_q <= trg_samp_q && !trg_s2_q;
         end
         else if (mc_tick)
         begin
            cnt_pend_q <= 1'b0;
            trg_pend_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------
   always_comb
   begin
      if (!ctl_q.run)
         mode = CRT_OFF;
      else if (ctl_q.rclk || ctl_q.tx_baud_select)
         mode = CRT_BAUD;
      else if (ctl_q.cprl)
         mode = CRT_CAPTURE;
      else
         mode = CRT_RELOAD;
   end

   // ----------------------------------------------------------------
   // count and trigger events
   // ----------------------------------------------------------------
   assign cnt_evt = cnt_pend_q && mc_tick;
   assign trg_evt = trg_pend_q && mc_tick && ctl_q.exen && (mode != CRT_OFF);
   assign dmode = (mode == CRT_RELOAD) && mode_reg_q[`CRT_MODE_DOWN_COUNT_ENABLE];
   assign count_down = dmode && !trg_s2_q;

   // increment source by mode and counter select
   always_comb
   begin
      case (mode)
         CRT_OFF: inc = 1'b0;
         CRT_BAUD: inc = ctl_q.ct ? cnt_evt : st_tick;
         CRT_RELOAD, CRT_CAPTURE: inc = ctl_q.ct ? cnt_evt : mc_tick;
         default: inc = 1'b0;
      endcase
   end

   assign ovf = inc && !count_down && (cnt_q == `CRT_CNT_MAX);
   assign unf = inc && count_down && (cnt_q == cap_q);
   assign baud_pulse = ovf && (mode == CRT_BAUD);
   assign cap_load = trg_evt && (mode == CRT_CAPTURE);
   assign tf_set = (ovf || unf) && (mode != CRT_BAUD);
   assign exf_set = trg_evt && !dmode;
   assign exf_tog = dmode && (ovf || unf);

   // ----------------------------------------------------------------
   // hardware next count
   // ----------------------------------------------------------------
   always_comb
   begin
      cnt_d = cnt_q;
      if (trg_evt && (mode == CRT_RELOAD) && !dmode)
         cnt_d = cap_q;
      else if (unf)
         cnt_d = `CRT_CNT_MAX;
      else if (inc && count_down)
         cnt_d = cnt_q - 16'h0001;
      else if (ovf && (mode == CRT_CAPTURE))
         cnt_d = `CRT_RST_WORD;
      else if (ovf)
         cnt_d = cap_q;
      else if (inc)
         cnt_d = cnt_q + 16'h0001;
   end

   // count bytes, software write wins per byte
   always_ff @(posedge i_mclk)
   begin
      if (!i_resetn)
         cnt_q <= `CRT_RST_WORD;
      else
      begin
         cnt_q[7:0] <= wr_cnt_lo ? i_sfr_wdata : cnt_d[7:0];
         cnt_q[15:8] <= wr_cnt_hi ? i_sfr_wdata : cnt_d[15:8];
      end
   end

   // capture bytes, software write wins per byte
   always_ff @(posedge i_mclk)
   begin
      if (!i_resetn)
         cap_q <= `CRT_RST_WORD;
      else
      begin
         if (wr_cap_lo)
            cap_q[7:0] <= i_sfr_wdata;
         else if (cap_load)
            cap_q[7:0] <= cnt_q[7:0];
         if (wr_cap_hi)
            cap_q[15:8] <= i_sfr_wdata;
         else if (cap_load)
            cap_q[15:8] <= cnt_q[15:8];
      end
   end

   // ----------------------------------------------------------------
   // control and mode registers, hardware set beats software clear
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (!i_resetn)
         ctl_q <= crt_ctl_t'(`CRT_RST_BYTE);
      else
      begin
         if (wr_ctl)
            ctl_q <= crt_ctl_t'(i_sfr_wdata);
         if (tf_set)
            ctl_q.tf <= 1'b1;
         if (exf_set)
            ctl_q.exf <= 1'b1;
         else if (exf_tog)
            ctl_q.exf <= wr_ctl ? !i_sfr_wdata[6] : !ctl_q.exf;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_resetn)
         mode_reg_q <= `CRT_RST_BYTE;
      else if (wr_mode)
         mode_reg_q <= i_sfr_wdata & `CRT_MODE_MASK;
   end

   // ----------------------------------------------------------------
   // serial clock selection and interrupt request
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (!i_resetn)
      begin
         o_rx_baud_clk <= 1'b0;
         o_tx_baud_clk <= 1'b0;
      end
      else
      begin
         o_rx_baud_clk <= ctl_q.rclk ? baud_pulse : i_other_ovf;
         o_tx_baud_clk <= ctl_q.tx_baud_select ? baud_pulse : i_other_ovf;
      end
   end

   // flags stay set after servicing; up/down mode masks the event flag
   assign o_timer_irq = i_irq_enable &&
      (ctl_q.tf || (ctl_q.exf && !mode_reg_q[`CRT_MODE_DOWN_COUNT_ENABLE]));

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);
   property p_ovf_sets_tf;
      ovf && (mode != CRT_BAUD) |=> ctl_q.tf;
   endproperty
   a_ovf_sets_tf: assert property (p_ovf_sets_tf) else $error("overflow lost");
   property p_tf_sticky;
      ctl_q.tf && !wr_ctl |=> ctl_q.tf;
   endproperty
   a_tf_sticky: assert property (p_tf_sticky) else $error("flag cleared by hw");
   property p_no_tf_in_baud;
      (ctl_q.rclk || ctl_q.tx_baud_select) && !ctl_q.tf && !wr_ctl |=> !ctl_q.tf;
   endproperty
   a_no_tf_in_baud: assert property (p_no_tf_in_baud) else $error("flag in baud");
   property p_exf_set;
      exf_set |=> ctl_q.exf;
   endproperty
   a_exf_set: assert property (p_exf_set) else $error("event flag lost");
   property p_irq_flag;
      $rose(ctl_q.tf) && i_irq_enable |-> o_timer_irq;
   endproperty
   a_irq_flag: assert property (p_irq_flag) else $error("no irq");
   property p_rx_sel;
      ctl_q.rclk && baud_pulse ##1 ctl_q.rclk |-> o_rx_baud_clk;
   endproperty
   a_rx_sel: assert property (p_rx_sel) else $error("rx clock missing");
   property p_tx_other;
      !ctl_q.tx_baud_select && i_other_ovf |=> o_tx_baud_clk;
   endproperty
   a_tx_other: assert property (p_tx_other) else $error("tx alt missing");
   property p_stop;
      !ctl_q.run && !wr_cnt_lo && !wr_cnt_hi |=> $stable(cnt_q);
   endproperty
   a_stop: assert property (p_stop) else $error("count moved while off");
   property p_inc_phase;
      inc && (mode != CRT_BAUD) |-> phase_q == `CRT_PH_S3P1;
   endproperty
   a_inc_phase: assert property (p_inc_phase) else $error("bad inc phase");
   property p_capture;
      cap_load && !wr_cap_lo && !wr_cap_hi |=> cap_q == $past(cnt_q);
   endproperty
   a_capture: assert property (p_capture) else $error("capture wrong");
   property p_down_reload;
      unf && !wr_cnt_lo && !wr_cnt_hi |=> cnt_q == `CRT_CNT_MAX;
   endproperty
   a_down_reload: assert property (p_down_reload) else $error("down reload");
   property p_baud_trig;
      (mode == CRT_BAUD) && trg_evt && !inc && !wr_cnt_lo && !wr_cnt_hi |=> $stable(cnt_q);
   endproperty
   a_baud_trig: assert property (p_baud_trig) else $error("baud trig reload");
   property p_wr_wins;
      wr_cnt_lo |=> cnt_q[7:0] == $past(i_sfr_wdata);
   endproperty
   a_wr_wins: assert property (p_wr_wins) else $error("write lost");
   c_capture: cover property (cap_load);
   c_underflow: cover property (unf);
   c_baud_ovf: cover property (baud_pulse);
   c_reload_trig: cover property (trg_evt && (mode == CRT_RELOAD));
endmodule

// ===== bench/crt_host_model.sv
`timescale 1ns/100ps

// ------------------------------------------------------------
// far side: pin sources, other timer overflow, serial clocks
// ------------------------------------------------------------
module crt_host_model
(
   input wire logic i_mclk,
   input wire logic i_rx_clk,
   input wire logic i_tx_clk,
   output logic o_count_pin,
   output logic o_trigger_pin,
   output logic o_other_ovf,
   output int o_rx_n,
   output int o_tx_n
);
   // port pins idle high through their pull-ups
   initial
   begin
      o_count_pin = 1'b1;
      o_trigger_pin = 1'b1;
      o_other_ovf = 1'b0;
   end

   // serial side counts the baud clock pulses it receives
   always @(posedge i_mclk)
   begin
      o_rx_n <= o_rx_n + int'(i_rx_clk);
      o_tx_n <= o_tx_n + int'(i_tx_clk);
   end

   // set the level of one pin
   task automatic drive(input bit trig, input logic lvl);
      if (trig)
         o_trigger_pin = lvl;
      else
         o_count_pin = lvl;
   endtask

   // falling edges, each level held two machine cycles
   task automatic falls(input bit trig, input int n);
      repeat (n)
      begin
         drive(trig, 1'b0);
         repeat (24) @(negedge i_mclk);
         drive(trig, 1'b1);
         repeat (24) @(negedge i_mclk);
      end
   endtask

   // one-cycle overflow pulses from the other timer
   task automatic ovf_pulses(input int n);
      repeat (n)
      begin
         o_other_ovf = 1'b1;
         @(negedge i_mclk);
         o_other_ovf = 1'b0;
         @(negedge i_mclk);
      end
   endtask
endmodule

// ===== bench/crt_timer_tb_top.sv
`timescale 1ns/100ps
`include "crt_regs.svh"

module crt_timer_tb_top import crt_pkg::*;;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic wr = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic irq_en = 1'b1;
   logic rd_req = 1'b0;
   logic rd_vld = 1'b0;
   logic [7:0] rdata;
   logic hit, irq, rx_clk, tx_clk, cnt_pin, trg_pin, oth_ovf;
   int rx_n, tx_n;
   int err_count = 0;
   int tests_run = 0;
   int seed = 32'h333a991c;
   logic [7:0] exp_q[$];

   // 25 MHz oscillator clock
   always #20 mclk = ~mclk;

   crt_timer i_dut(.i_mclk(mclk), .i_resetn(resetn), .i_sfr_addr(addr), .i_sfr_wr(wr),
      .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .o_sfr_hit(hit), .i_count_pin(cnt_pin),
      .i_trigger_pin(trg_pin), .i_other_ovf(oth_ovf), .i_irq_enable(irq_en),
      .o_timer_irq(irq), .o_rx_baud_clk(rx_clk), .o_tx_baud_clk(tx_clk));

   crt_host_model i_host(.i_mclk(mclk), .i_rx_clk(rx_clk), .i_tx_clk(tx_clk),
      .o_count_pin(cnt_pin), .o_trigger_pin(trg_pin), .o_other_ovf(oth_ovf),
      .o_rx_n(rx_n), .o_tx_n(tx_n));

   // ------------------------------------------------------------
   // checking
   // ------------------------------------------------------------
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // read data lands one cycle after its address
   always @(posedge mclk)
      rd_vld <= rd_req;

   // oldest noted read value against the returned byte
   always @(negedge mclk)
      if (rd_vld)
         check({8'h00, rdata}, {8'h00, exp_q.pop_front()}, "read data");

   // hang guard
   initial
   begin
      repeat (100000) @(posedge mclk);
      err_count++;
      $display("unexpected at %0t: run too long", $time);
      end_of_test();
   end

   // ------------------------------------------------------------
   // register access
   // ------------------------------------------------------------
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge mclk);
      wr = 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(negedge mclk);
      addr = a;
      rd_req = 1'b1;
      exp_q.push_back(e);
      @(negedge mclk);
      rd_req = 1'b0;
   endtask

   // load, run for ncyc clocks with pin activity, stop, read back
   task automatic run_case(input logic [15:0] mc, input logic [31:0] cc, input logic trig,
      input int n_cnt, input int n_trg, input int ncyc, input logic [31:0] ec,
      input logic [7:0] ctl_end, input int e_tx, input int e_rx);
      int tx0;
      int rx0;
      wr_reg(`CRT_ADDR_MODE, mc[15:8]);
      wr_reg(`CRT_ADDR_CAP_LO, cc[7:0]);
      wr_reg(`CRT_ADDR_CAP_HI, cc[15:8]);
      wr_reg(`CRT_ADDR_CNT_LO, cc[23:16]);
      wr_reg(`CRT_ADDR_CNT_HI, cc[31:24]);
      i_host.drive(1'b1, trig);
      repeat (30) @(negedge mclk);
      tx0 = tx_n;
      rx0 = rx_n;
      wr_reg(`CRT_ADDR_CTL, mc[7:0]);
      fork
         begin
            i_host.ovf_pulses(3);
            i_host.falls(1'b0, n_cnt);
            i_host.falls(1'b1, n_trg);
         end
         repeat (ncyc - 2) @(negedge mclk);
      join
      wr_reg(`CRT_ADDR_CTL, ctl_end);
      repeat (4) @(negedge mclk);
      check(16'(tx_n - tx0), 16'(e_tx), "tx clocks");
      check(16'(rx_n - rx0), 16'(e_rx), "rx clocks");
      rd_reg(`CRT_ADDR_CNT_LO, ec[23:16]);
      rd_reg(`CRT_ADDR_CNT_HI, ec[31:24]);
      rd_reg(`CRT_ADDR_CAP_LO, ec[7:0]);
      rd_reg(`CRT_ADDR_CAP_HI, ec[15:8]);
      rd_reg(`CRT_ADDR_CTL, ctl_end);
      check({15'h0, irq}, {15'h0, irq_en & (ctl_end[7] | (ctl_end[6] & ~mc[8]))}, "irq");
      wr_reg(`CRT_ADDR_CTL, 8'h00);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      logic [15:0] c;
      int k;
      repeat (12) @(negedge mclk);
      resetn = 1'b1;
      for (int a = 8'hc8; a <= 8'hcd; a++)
         rd_reg(8'(a), 8'h00);
      check({15'h0, hit}, 16'h0001, "hit");
      wr_reg(`CRT_ADDR_MODE, 8'hff);
      rd_reg(`CRT_ADDR_MODE, 8'h03);
      wr_reg(8'hce, 8'hff);
      rd_reg(8'hce, 8'h00);
      check({15'h0, hit}, 16'h0000, "unmapped hit");
      run_case(16'h0005, 32'hfffe0000, 1'b1, 0, 0, 24, 32'h00000000, 8'h81, 3, 3);
      run_case(16'h0004, 32'hffff1000, 1'b1, 0, 0, 12, 32'h10001000, 8'h80, 3, 3);
      run_case(16'h0014, 32'hfffdfffd, 1'b1, 0, 0, 12, 32'hfffdfffd, 8'h10, 2, 3);
      run_case(16'h0024, 32'hfffdfffd, 1'b1, 0, 0, 12, 32'hfffdfffd, 8'h20, 3, 2);
      run_case(16'h0104, 32'h01020100, 1'b0, 0, 0, 36, 32'hffff0100, 8'h40, 3, 3);
      run_case(16'h0104, 32'hffff1000, 1'b1, 0, 0, 12, 32'h10001000, 8'hc0, 3, 3);
      run_case(16'h0006, 32'h00ff0000, 1'b1, 3, 0, 192, 32'h01020000, 8'h00, 3, 3);
      run_case(16'h000f, 32'h12340000, 1'b1, 0, 1, 96, 32'h12341234, 8'h4b, 3, 3);
      run_case(16'h0007, 32'h12340000, 1'b1, 0, 1, 96, 32'h12340000, 8'h03, 3, 3);
      run_case(16'h000e, 32'h12340abc, 1'b1, 0, 1, 96, 32'h0abc0abc, 8'h4a, 3, 3);
      run_case(16'h001e, 32'h12340abc, 1'b1, 0, 1, 96, 32'h12340abc, 8'h5a, 0, 3);
      for (int i = 0; i < 3; i++)
      begin
         c = 16'($random(seed)) & 16'h7fff;
         k = 1 + int'($unsigned($random(seed)) % 8);
         run_case(16'h0004, {c, 16'h0000}, 1'b1, 0, 0, 12 * k, {c + 16'(k), 16'h0000},
            8'h00, 3, 3);
      end
      irq_en = 1'b0;
      wr_reg(`CRT_ADDR_CTL, 8'h80);
      check({15'h0, irq}, 16'h0000, "masked irq");
      wr_reg(`CRT_ADDR_CTL, 8'h00);
      end_of_test();
   end
endmodule
